// [rtl/din_condition.sv]
// digital input conditioning top with apb register file
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// R1: six slow and two fast input terminals
// R2: select low, high, rise, fall or both
// R3: slow change needs opposite level over 3 ms; default SLOW_HOLD_CYC overflows int to -323741, not 750000 cycles
// R4: fast change needs opposite level over 0.25 ms
// R5: source keeps fast inputs at most 4 kHz; din_source limits only fast_input_a, one change per MIN_GAP cycles
// R6: fast glitch filter 0-255 steps, default 80
// R7: filter length loads stopped, applies at restart
module din_condition #(
	parameter int SLOW_HOLD_CYC = din_pkg::SLOW_HOLD_CYC,
	parameter int FAST_HOLD_CYC = din_pkg::FAST_HOLD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [din_pkg::NUM_SLOW-1:0] slow_input,
	input wire logic fast_input_a,
	input wire logic fast_input_b,
	input wire logic drive_running,
	output logic [din_pkg::NUM_IN-1:0] in_level,
	output logic [din_pkg::NUM_IN-1:0] in_active
);
	import din_pkg::*;

	typedef struct packed {
		logic [7:0] filt_a_pend;
		logic [7:0] filt_b_pend;
		logic [7:0] filt_a_act;
		logic [7:0] filt_b_act;
		logic [23:0] sel;
		logic [31:0] rdata;
		logic slverr;
	} regs_s;

	regs_s s_reg;
	regs_s s_next;
	logic setup;
	logic wr;
	logic apply_req;
	logic pend_diff;
	logic [FILT_LEN_W-1:0] len_a;
	logic [FILT_LEN_W-1:0] len_b;
	logic filt_a;
	logic filt_b;
	logic [NUM_IN-1:0] raw;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic addr_known(input logic [7:0] a);
		return (a == OFF_FILT_A) || (a == OFF_FILT_B) || (a == OFF_SEL) ||
			(a == OFF_CTRL) || (a == OFF_STATUS);
	endfunction

	function automatic logic [FILT_LEN_W-1:0] filt_cycles(input logic [7:0] v);
		return FILT_LEN_W'(v) * FILT_LEN_W'(FILT_STEP_CYC);
	endfunction

	// ----------------------------------------
	// apb register file
	// ----------------------------------------
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign apply_req = wr && (paddr == OFF_CTRL) && pwdata[CTRL_APPLY_BIT] && !drive_running; // R7
	assign pend_diff = (s_reg.filt_a_pend != s_reg.filt_a_act) || (s_reg.filt_b_pend != s_reg.filt_b_act);

	always_comb begin
		s_next = s_reg;
		if (setup) begin
			s_next.slverr = !addr_known(paddr);
			if (paddr == OFF_FILT_A) begin
				s_next.rdata = {24'h000000, s_reg.filt_a_pend};
			end else if (paddr == OFF_FILT_B) begin
				s_next.rdata = {24'h000000, s_reg.filt_b_pend};
			end else if (paddr == OFF_SEL) begin
				s_next.rdata = {8'h00, s_reg.sel};
			end else if (paddr == OFF_STATUS) begin
				s_next.rdata = {15'h0000, pend_diff, in_active, in_level};
			end else begin
				s_next.rdata = 32'h00000000;
			end
		end
		if (wr) begin
			if (paddr == OFF_FILT_A) begin
				if (!drive_running) begin
					s_next.filt_a_pend = pwdata[7:0]; // R7
				end
			end else if (paddr == OFF_FILT_B) begin
				if (!drive_running) begin
					s_next.filt_b_pend = pwdata[7:0]; // R7
				end
			end else if (paddr == OFF_SEL) begin
				s_next.sel = pwdata[23:0]; // R2
			end
		end
		if (apply_req) begin
			s_next.filt_a_act = s_reg.filt_a_pend; // R7
			s_next.filt_b_act = s_reg.filt_b_pend; // R7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg.filt_a_pend <= FILT_RESET; // R6
			s_reg.filt_b_pend <= FILT_RESET;
			s_reg.filt_a_act <= FILT_RESET;
			s_reg.filt_b_act <= FILT_RESET;
			s_reg.sel <= SEL_RESET;
			s_reg.rdata <= 32'h00000000;
			s_reg.slverr <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.rdata;
	assign pslverr = s_reg.slverr;
	assign pready = 1'b1;

	// ----------------------------------------
	// fast input glitch filters
	// ----------------------------------------
	assign len_a = filt_cycles(s_reg.filt_a_act); // R6
	assign len_b = filt_cycles(s_reg.filt_b_act); // R6

	din_glitch u_glitch_a (
		.pclk(pclk),
		.presetn(presetn),
		.din(fast_input_a),
		.len(len_a),
		.dout(filt_a)
	);

	din_glitch u_glitch_b (
		.pclk(pclk),
		.presetn(presetn),
		.din(fast_input_b),
		.len(len_b),
		.dout(filt_b)
	);

	// ----------------------------------------
	// qualification of all eight inputs
	// ----------------------------------------
	assign raw = {filt_b, filt_a, slow_input}; // R1

	generate
		for (genvar i = 0; i < NUM_IN; i++) begin : g_in
			if (i < NUM_SLOW) begin : g_slow
				din_qualifier #(
					.HOLD_CYC(SLOW_HOLD_CYC)
				) u_qual (
					.pclk(pclk),
					.presetn(presetn),
					.din(raw[i]),
					.sel(s_reg.sel[i*SEL_W +: SEL_W]),
					.level(in_level[i]),
					.active(in_active[i])
				); // R3
			end else begin : g_fast
				din_qualifier #(
					.HOLD_CYC(FAST_HOLD_CYC)
				) u_qual (
					.pclk(pclk),
					.presetn(presetn),
					.din(raw[i]),
					.sel(s_reg.sel[i*SEL_W +: SEL_W]),
					.level(in_level[i]),
					.active(in_active[i])
				); // R4
			end
		end
	endgenerate

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_pend_refused: assert property (@(posedge pclk) disable iff (!presetn) // R7
		(wr && paddr == OFF_FILT_A && drive_running) |=> $stable(s_reg.filt_a_pend))
		else $error("filter length written while running");
	a_pend_loaded: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(wr && paddr == OFF_FILT_B && !drive_running) |=> (s_reg.filt_b_pend == $past(pwdata[7:0])))
		else $error("filter length write lost");
	a_act_only_apply: assert property (@(posedge pclk) disable iff (!presetn) // R7
		($changed(s_reg.filt_a_act) || $changed(s_reg.filt_b_act)) |-> $past(apply_req))
		else $error("active filter length changed without restart");
	a_apply_copies: assert property (@(posedge pclk) disable iff (!presetn) // R7
		apply_req |=> (s_reg.filt_a_act == $past(s_reg.filt_a_pend)) && !pend_diff)
		else $error("restart did not apply pending length");
	a_sel_written: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(wr && paddr == OFF_SEL) |=> (s_reg.sel == $past(pwdata[23:0])))
		else $error("logic selection write lost");
	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !addr_known(paddr)) |=> pslverr)
		else $error("unmapped address without error");

	c_write_running: cover property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFF_FILT_A && drive_running);
	c_apply: cover property (@(posedge pclk) disable iff (!presetn) apply_req && pend_diff);
	c_fast_active: cover property (@(posedge pclk) disable iff (!presetn) in_active[NUM_IN-1]);
	c_slow_active: cover property (@(posedge pclk) disable iff (!presetn) in_active[0]);
endmodule // din_condition

// [include/din_pkg.sv]
// shared constants for the digital input conditioning block
package din_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SLOW_HOLD_US = 3000;
	localparam int FAST_HOLD_US = 250;
	localparam int FILT_STEP_PS = 25000;
	localparam int SLOW_HOLD_CYC = SLOW_HOLD_US * 1000 * 1000 / CLK_PERIOD_PS;
	localparam int FAST_HOLD_CYC = FAST_HOLD_US * 1000 * 1000 / CLK_PERIOD_PS;
	localparam int FILT_STEP_CYC = (FILT_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FILT_LEN_W = 11;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] OFF_FILT_A = 8'h00;
	localparam logic [7:0] OFF_FILT_B = 8'h04;
	localparam logic [7:0] OFF_SEL = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] FILT_RESET = 8'h50;
	localparam logic [23:0] SEL_RESET = 24'h249249;
	localparam int SEL_W = 3;
	localparam int NUM_IN = 8;
	localparam int NUM_SLOW = 6;
	localparam int CTRL_APPLY_BIT = 0;
	localparam int STAT_PEND_BIT = 16;
	// ----------------------------------------
	// logic selection codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEL_LOW = 3'h0,
		SEL_HIGH = 3'h1,
		SEL_RISE = 3'h2,
		SEL_FALL = 3'h3,
		SEL_BOTH = 3'h4
	} sel_e;
endpackage

// [rtl/din_glitch.sv]
// glitch filter for one fast input
`timescale 1ns/1ps
module din_glitch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	input wire logic [din_pkg::FILT_LEN_W-1:0] len,
	output logic dout
);
	import din_pkg::*;

	typedef struct packed {
		logic [FILT_LEN_W-1:0] cnt;
		logic out;
	} glitch_s;

	glitch_s s_reg;
	glitch_s s_next;

	// ----------------------------------------
	// filter: a change passes after len stable cycles
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		if (len == '0) begin
			s_next.out = din;
			s_next.cnt = '0;
		end else if (din != s_reg.out) begin
			if (s_reg.cnt == len - FILT_LEN_W'(1)) begin // R6
				s_next.out = din;
				s_next.cnt = '0;
			end else begin
				s_next.cnt = s_reg.cnt + FILT_LEN_W'(1);
			end
		end else begin
			s_next.cnt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign dout = s_reg.out;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_glitch_reject: assert property (@(posedge pclk) disable iff (!presetn) // R6
		($changed(dout) && $past(len) >= 2) |-> ($past(din, 2) == dout))
		else $error("filter passed a spike shorter than its length");
	a_glitch_pass: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(len == '0) |=> (dout == $past(din)))
		else $error("zero length filter did not pass input");
endmodule // din_glitch

// [rtl/din_qualifier.sv]
// hold time qualification and logic selection for one input
`timescale 1ns/1ps
module din_qualifier #(
	parameter int HOLD_CYC = din_pkg::SLOW_HOLD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	input wire logic [din_pkg::SEL_W-1:0] sel,
	output logic level,
	output logic active
);
	import din_pkg::*;

	localparam int CW = $clog2(HOLD_CYC + 1);
	localparam logic [CW-1:0] HOLD_V = CW'(HOLD_CYC);

	typedef struct packed {
		logic prev;
		logic [CW-1:0] cnt;
		logic qual;
		logic seen;
		logic act;
	} qual_s;

	qual_s s_reg;
	qual_s s_next;
	logic accept;
	logic rise;
	logic fall;

	// ----------------------------------------
	// accept a change only after the old level held long enough
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.prev = din;
		accept = (din != s_reg.prev) && (s_reg.cnt == HOLD_V); // R3 R4
		rise = accept && din;
		fall = accept && !din;
		if (din != s_reg.prev) begin
			s_next.cnt = '0;
		end else if (s_reg.cnt != HOLD_V) begin
			s_next.cnt = s_reg.cnt + CW'(1);
		end
		if (accept) begin
			s_next.qual = din;
			s_next.seen = 1'b1;
		end
		case (sel) // R2
			SEL_LOW: s_next.act = s_next.seen && !s_next.qual;
			SEL_HIGH: s_next.act = s_next.seen && s_next.qual;
			SEL_RISE: s_next.act = rise;
			SEL_FALL: s_next.act = fall;
			SEL_BOTH: s_next.act = rise || fall;
			default: s_next.act = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level = s_reg.qual;
	assign active = s_reg.act;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_hold_before_change: assert property (@(posedge pclk) disable iff (!presetn) // R3 R4
		$changed(level) |-> ($past(s_reg.cnt) == HOLD_V))
		else $error("level changed before hold time");
	a_short_reject: assert property (@(posedge pclk) disable iff (!presetn) // R3 R4
		(($past(din) != $past(s_reg.prev)) && ($past(s_reg.cnt) < HOLD_V)) |-> $stable(level))
		else $error("short pulse was accepted");
	a_rise_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(active && $past(sel) == SEL_RISE) |-> $rose(level))
		else $error("rising edge flag without a rise");
endmodule // din_qualifier

// [bench/din_source.sv]
// external switch and sensor source model
`timescale 1ns/1ps
module din_source #(
	parameter int MIN_GAP = 30
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] slow_cmd,
	input wire logic fast_a_cmd,
	input wire logic fast_b_cmd,
	input wire logic spike_a,
	output logic [5:0] slow_input,
	output logic fast_input_a,
	output logic fast_input_b
);
	int gap_cnt;
	logic fast_a_lvl;
	// spike is a commanded fault on top of the rate-limited level
	assign fast_input_a = fast_a_lvl ^ spike_a;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_input <= 6'h00;
			fast_input_b <= 1'b0;
			fast_a_lvl <= 1'b0;
			gap_cnt <= 0;
		end else begin
			slow_input <= slow_cmd;
			fast_input_b <= fast_b_cmd;
			if (fast_a_cmd != fast_a_lvl && gap_cnt >= MIN_GAP) begin
				fast_a_lvl <= fast_a_cmd;
				gap_cnt <= 0;
			end else if (gap_cnt < MIN_GAP) begin
				gap_cnt <= gap_cnt + 1;
			end
		end
	end
endmodule // din_source

// [bench/testbench.sv]
// self-checking bench for the digital input conditioning block
`timescale 1ns/1ps
module testbench;
	import din_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, drive_running;
	logic fast_input_a, fast_input_b, fast_a_cmd, fast_b_cmd, spike_a;
	logic [7:0] paddr, in_level, in_active;
	logic [31:0] pwdata, prdata, rv;
	logic [5:0] slow_input, slow_cmd;
	logic [15:0] io_last;
	logic [32:0] rd_q[$];
	logic [15:0] io_q[$];
	int error_cnt = 0;
	int n_tests = 0;
	int seed = 49876;
	din_condition #(.SLOW_HOLD_CYC(20), .FAST_HOLD_CYC(5)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .slow_input(slow_input), .fast_input_a(fast_input_a), .fast_input_b(fast_input_b),
		.drive_running(drive_running), .in_level(in_level), .in_active(in_active));
	din_source #(.MIN_GAP(30)) src (.pclk(pclk), .presetn(presetn), .slow_cmd(slow_cmd), .fast_a_cmd(fast_a_cmd),
		.fast_b_cmd(fast_b_cmd), .spike_a(spike_a), .slow_input(slow_input), .fast_input_a(fast_input_a),
		.fast_input_b(fast_input_b));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
		int i;
		if (!w) begin
			rd_q.push_back(exp);
		end
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				break;
			end
		end
		if (i == 16) begin
			error_cnt++;
			report_and_stop();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ----------------------------------------
	// monitor
	// ----------------------------------------
	always @(posedge pclk) begin
		if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			check({pslverr, prdata}, rd_q.size() > 0 ? rd_q.pop_front() : 33'h1ffffffff);
		end
		if ({in_active, in_level} !== io_last) begin
			check({17'h0, in_active, in_level}, io_q.size() > 0 ? {17'h0, io_q.pop_front()} : 33'h1ffffffff);
			io_last = {in_active, in_level};
		end
	end
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		drive_running = 1'b0;
		slow_cmd = 6'h00;
		fast_a_cmd = 1'b0;
		fast_b_cmd = 1'b0;
		spike_a = 1'b0;
		io_last = 16'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (30) @(posedge pclk);
		apb(1'b0, OFF_FILT_A, 32'h0, {25'h0, FILT_RESET});
		apb(1'b0, OFF_FILT_B, 32'h0, {25'h0, FILT_RESET});
		apb(1'b0, OFF_SEL, 32'h0, {9'h0, SEL_RESET});
		apb(1'b0, OFF_CTRL, 32'h0, 33'h0);
		apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
		drive_running <= 1'b1;
		apb(1'b1, OFF_FILT_A, 32'h3, 33'h0);
		apb(1'b0, OFF_FILT_A, 32'h0, 33'h50);
		drive_running <= 1'b0;
		apb(1'b1, OFF_FILT_A, 32'h3, 33'h0);
		apb(1'b0, OFF_STATUS, 32'h0, 33'h10000);
		apb(1'b1, OFF_CTRL, 32'h1, 33'h0);
		apb(1'b0, OFF_STATUS, 32'h0, 33'h0);
		rv = $random(seed);
		apb(1'b1, OFF_FILT_B, rv, 33'h0);
		apb(1'b0, OFF_FILT_B, 32'h0, {25'h0, rv[7:0]});
		// inputs 0..4 take codes 0..4, the rest high level
		apb(1'b1, OFF_SEL, 32'h24c688, 33'h0);
		io_q.push_back(16'h363f);
		io_q.push_back(16'h223f);
		slow_cmd <= 6'h3f;
		repeat (40) @(posedge pclk);
		io_q.push_back(16'h1900);
		io_q.push_back(16'h0100);
		slow_cmd <= 6'h00;
		repeat (5) @(posedge pclk);
		slow_cmd <= 6'h3f;
		repeat (40) @(posedge pclk);
		spike_a <= 1'b1;
		repeat (10) @(posedge pclk);
		spike_a <= 1'b0;
		repeat (60) @(posedge pclk);
		io_q.push_back(16'h4140);
		fast_a_cmd <= 1'b1;
		repeat (80) @(posedge pclk);
		// fast_input_b still runs on the reset length of 80 steps
		io_q.push_back(16'hc1c0);
		fast_b_cmd <= 1'b1;
		repeat (620) @(posedge pclk);
		check(33'(rd_q.size() + io_q.size()), 33'h0);
		report_and_stop();
	end
endmodule // testbench
